/* verilog/pml_pkg.sv */
// package: memory type codes, table layout, reset values and entry bit positions
package pml_pkg;
  localparam int TBL_W = 64;
  localparam int SLOTS = 8;
  localparam int SLOT_W = 8;
  localparam int CODE_W = 3;
  localparam logic [7:0] MT_UC = 8'h00;
  localparam logic [7:0] MT_WC = 8'h01;
  localparam logic [7:0] MT_WT = 8'h04;
  localparam logic [7:0] MT_WP = 8'h05;
  localparam logic [7:0] MT_WB = 8'h06;
  localparam logic [7:0] MT_UCM = 8'h07;
  // cache-disabled result code, internal to the effective type output
  localparam logic [7:0] MT_CD = 8'h08;
  localparam logic [63:0] TBL_RESET = 64'h0007040600070406;
  localparam int LEAF_IDX_BIT = 7;
  localparam int DIR_IDX_BIT = 12;
  localparam int CD_BIT = 4;
  localparam int WT_BIT = 3;
  localparam int FEAT_BIT = 16;
  typedef enum logic [1:0] {
    pml_lvl_upper,
    pml_lvl_leaf,
    pml_lvl_large
  } pml_level_t;
  typedef struct packed {
    logic valid;
    pml_level_t level;
    logic [63:0] entry;
    logic [7:0] range_type;
    logic range_en;
  } pml_req_t;
  typedef struct packed {
    logic valid;
    logic [2:0] slot;
    logic [7:0] table_type;
    logic [7:0] eff_type;
  } pml_rsp_t;
endpackage : pml_pkg

/* verilog/pml_lookup.sv */
// memory type lookup table, slot selection and effective type combination
// Operation
// - one 64-bit table holds eight memory type slots zero to seven
// - slot codes are range-type codes plus 07h for uncacheable minus
// - 07h acts like 00h except write-combining range type overrides it
// - nonzero reserved bit in a write faults and leaves table unchanged
// - unsupported code in any slot faults; supported codes allowed anywhere
// - reset slots: write back, write through, uncacheable minus, uncacheable, twice
// - slot index is table-index, cache-disable, write-through bits, msb first
// - table-index bit is bit 7 leaf, bit 12 large directory, else zero
// - cache-disable bit 4 and write-through bit 3 from the selected entry
// - lookup always active, no software control disables it
// - feature bit 16 of the identification result is set
// - every paged access selects a slot and applies its type
// - upper-level table fetches index only the first four slots
// - uncacheable and uncacheable minus combine with range type as listed
// - write-combining always wins; write-protect combines as listed
// - write-through combines as listed; write back passes range type
// - disabled range registers give uncacheable as the range type
// - write-through: allocate on read miss shared only, write hits update both
// - write-protect: writes reach memory, no write allocate, write hits invalidate
module pml_lookup (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // table access from privileged software
  input wire logic wr_en_i,
  input wire logic [63:0] wr_data_i,
  output logic [63:0] memtype_lookup_table_o,
  output logic general_protection_fault_o,
  // feature identification
  output logic [31:0] feat_edx_o,
  // translation request and result
  input wire pml_pkg::pml_req_t req_i,
  output pml_pkg::pml_rsp_t rsp_o,
  // cache policy for the access
  output logic rd_miss_alloc_o,
  output logic rd_alloc_shared_only_o,
  output logic wr_miss_alloc_o,
  output logic wr_hit_update_mem_o,
  output logic wr_hit_invalidate_o
);
  logic [63:0] memtype_lookup_table;
  logic [7:0] slot_ok;
  logic wr_bad;

  function automatic logic code_ok(input logic [7:0] c);
    code_ok = (c == pml_pkg::MT_UC) || (c == pml_pkg::MT_WC) || (c == pml_pkg::MT_WT) ||
              (c == pml_pkg::MT_WP) || (c == pml_pkg::MT_WB) || (c == pml_pkg::MT_UCM);
  endfunction : code_ok

  // upper five bits of each byte are reserved, so the full byte is checked
  genvar g;
  generate
    for (g = 0; g < pml_pkg::SLOTS; g++) begin : g_chk
      assign slot_ok[g] = code_ok(wr_data_i[g*pml_pkg::SLOT_W +: pml_pkg::SLOT_W]);
    end
  endgenerate
  assign wr_bad = ~&slot_ok;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      memtype_lookup_table <= pml_pkg::TBL_RESET;
    end else if (wr_en_i && !wr_bad) begin
      memtype_lookup_table <= wr_data_i;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      general_protection_fault_o <= 1'b0;
    end else begin
      general_protection_fault_o <= wr_en_i && wr_bad;
    end
  end

  assign memtype_lookup_table_o = memtype_lookup_table;
  assign feat_edx_o = 32'h00000001 << pml_pkg::FEAT_BIT;

  // slot index; no enable exists, the lookup is always in use
  logic idx_hi;
  logic [2:0] next_slot;
  logic [7:0] tbl_type;
  logic [7:0] rng;
  logic [7:0] next_eff;
  always_comb begin
    idx_hi = 1'b0;
    case (req_i.level)
      pml_pkg::pml_lvl_leaf: idx_hi = req_i.entry[pml_pkg::LEAF_IDX_BIT];
      pml_pkg::pml_lvl_large: idx_hi = req_i.entry[pml_pkg::DIR_IDX_BIT];
      default: idx_hi = 1'b0;
    endcase
    next_slot = {idx_hi, req_i.entry[pml_pkg::CD_BIT], req_i.entry[pml_pkg::WT_BIT]};
    tbl_type = memtype_lookup_table[next_slot*pml_pkg::SLOT_W +: pml_pkg::SLOT_W];
    rng = req_i.range_en ? req_i.range_type : pml_pkg::MT_UC;
  end

  always_comb begin
    next_eff = pml_pkg::MT_CD;
    case (tbl_type)
      pml_pkg::MT_UC: next_eff = (rng == pml_pkg::MT_UC) ? pml_pkg::MT_UC : pml_pkg::MT_CD;
      pml_pkg::MT_UCM: begin
        if (rng == pml_pkg::MT_UC) begin
          next_eff = pml_pkg::MT_UC;
        end else if (rng == pml_pkg::MT_WC) begin
          next_eff = pml_pkg::MT_WC;
        end else begin
          next_eff = pml_pkg::MT_CD;
        end
      end
      pml_pkg::MT_WC: next_eff = pml_pkg::MT_WC;
      pml_pkg::MT_WP: begin
        case (rng)
          pml_pkg::MT_UC: next_eff = pml_pkg::MT_UC;
          pml_pkg::MT_WP, pml_pkg::MT_WB: next_eff = pml_pkg::MT_WP;
          default: next_eff = pml_pkg::MT_CD;
        endcase
      end
      pml_pkg::MT_WT: begin
        case (rng)
          pml_pkg::MT_UC: next_eff = pml_pkg::MT_UC;
          pml_pkg::MT_WT, pml_pkg::MT_WB: next_eff = pml_pkg::MT_WT;
          default: next_eff = pml_pkg::MT_CD;
        endcase
      end
      pml_pkg::MT_WB: next_eff = rng;
      default: next_eff = pml_pkg::MT_CD;
    endcase
  end

  // registered result, one cycle after the request
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rsp_o <= '0;
    end else begin
      rsp_o.valid <= req_i.valid;
      rsp_o.slot <= next_slot;
      rsp_o.table_type <= tbl_type;
      rsp_o.eff_type <= next_eff;
    end
  end

  // policy follows the registered effective type
  always_comb begin
    rd_miss_alloc_o = 1'b0;
    rd_alloc_shared_only_o = 1'b0;
    wr_miss_alloc_o = 1'b0;
    wr_hit_update_mem_o = 1'b0;
    wr_hit_invalidate_o = 1'b0;
    case (rsp_o.eff_type)
      pml_pkg::MT_WT: begin
        rd_miss_alloc_o = 1'b1;
        rd_alloc_shared_only_o = 1'b1;
        wr_hit_update_mem_o = 1'b1;
      end
      pml_pkg::MT_WP: begin
        rd_miss_alloc_o = 1'b1;
        rd_alloc_shared_only_o = 1'b1;
        wr_hit_update_mem_o = 1'b1;
        wr_hit_invalidate_o = 1'b1;
      end
      pml_pkg::MT_WB: begin
        rd_miss_alloc_o = 1'b1;
        wr_miss_alloc_o = 1'b1;
      end
      default: wr_hit_update_mem_o = 1'b1;
    endcase
  end

  a_bad_wr_keeps: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_en_i && wr_bad |=> general_protection_fault_o && $stable(memtype_lookup_table))
    else $error("bad table write changed table or gave no fault");
  a_good_wr_loads: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_en_i && !wr_bad |=> memtype_lookup_table == $past(wr_data_i) && !general_protection_fault_o)
    else $error("good table write not taken");
  a_upper_first4: assert property (@(posedge clk_i) disable iff (rst_i)
    req_i.level == pml_pkg::pml_lvl_upper |=> !rsp_o.slot[2])
    else $error("upper level used high slot");
  a_slot_order: assert property (@(posedge clk_i) disable iff (rst_i)
    req_i.level == pml_pkg::pml_lvl_leaf |=> rsp_o.slot == {$past(req_i.entry[7]),
      $past(req_i.entry[4]), $past(req_i.entry[3])})
    else $error("leaf slot index wrong");
  a_large_idx: assert property (@(posedge clk_i) disable iff (rst_i)
    req_i.level == pml_pkg::pml_lvl_large |=> rsp_o.slot[2] == $past(req_i.entry[12]))
    else $error("large page index bit wrong");
  a_wc_wins: assert property (@(posedge clk_i) disable iff (rst_i)
    tbl_type == pml_pkg::MT_WC |=> rsp_o.eff_type == pml_pkg::MT_WC)
    else $error("write combining table type not kept");
  a_ucm_over: assert property (@(posedge clk_i) disable iff (rst_i)
    tbl_type == pml_pkg::MT_UCM && rng == pml_pkg::MT_WC |=> rsp_o.eff_type == pml_pkg::MT_WC)
    else $error("uncacheable minus not overridden");
  a_range_off: assert property (@(posedge clk_i) disable iff (rst_i)
    !req_i.range_en && tbl_type == pml_pkg::MT_WB |=> rsp_o.eff_type == pml_pkg::MT_UC)
    else $error("disabled range type not uncacheable");
  a_wt_policy: assert property (@(posedge clk_i) disable iff (rst_i)
    rsp_o.eff_type == pml_pkg::MT_WT |-> rd_alloc_shared_only_o && !wr_miss_alloc_o)
    else $error("write through policy wrong");
  a_feat_bit: assert property (@(posedge clk_i) feat_edx_o[16])
    else $error("feature bit clear");
  a_feat_onehot: assert property (@(posedge clk_i) $onehot(feat_edx_o))
    else $error("feature word has extra bits");

  // reset state is checked while reset is still applied
  a_reset_table: assert property (@(posedge clk_i)
    rst_i |-> memtype_lookup_table == pml_pkg::TBL_RESET)
    else $error("table not at reset value");
  a_reset_quiet: assert property (@(posedge clk_i)
    rst_i |-> !rsp_o.valid && !general_protection_fault_o)
    else $error("outputs active in reset");

  // table only moves on a write
  a_tbl_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    !wr_en_i |=> $stable(memtype_lookup_table))
    else $error("table changed without a write");
  a_fault_cause: assert property (@(posedge clk_i) disable iff (rst_i)
    general_protection_fault_o |-> $past(wr_en_i))
    else $error("fault without a write");
  a_no_fault_idle: assert property (@(posedge clk_i) disable iff (rst_i)
    !wr_en_i |=> !general_protection_fault_o)
    else $error("fault after idle cycle");

  // stored slots stay legal, so a bad code can never reach the lookup
  for (g = 0; g < pml_pkg::SLOTS; g++) begin : g_slot_chk
    a_slot_rsvd: assert property (@(posedge clk_i) disable iff (rst_i)
      memtype_lookup_table[g*8+3 +: 5] == 5'h00)
      else $error("reserved slot bits set");
    a_slot_code: assert property (@(posedge clk_i) disable iff (rst_i)
      memtype_lookup_table[g*8 +: 3] inside {3'h0, 3'h1, 3'h4, 3'h5, 3'h6, 3'h7})
      else $error("unsupported code stored");
  end

  // lookup path
  a_rsp_valid: assert property (@(posedge clk_i) disable iff (rst_i)
    req_i.valid |=> rsp_o.valid)
    else $error("response valid missing");
  a_rsp_idle: assert property (@(posedge clk_i) disable iff (rst_i)
    !req_i.valid |=> !rsp_o.valid)
    else $error("response valid without request");
  a_type_sel: assert property (@(posedge clk_i) disable iff (rst_i)
    1'b1 |=> rsp_o.table_type == 8'($past(memtype_lookup_table) >> (rsp_o.slot * 8)))
    else $error("table type not from selected slot");
  a_large_low: assert property (@(posedge clk_i) disable iff (rst_i)
    req_i.level == pml_pkg::pml_lvl_large |=> rsp_o.slot[1:0] == $past(req_i.entry[4:3]))
    else $error("large page low index bits wrong");
  a_upper_low: assert property (@(posedge clk_i) disable iff (rst_i)
    req_i.level == pml_pkg::pml_lvl_upper |=> rsp_o.slot[1:0] == $past(req_i.entry[4:3]))
    else $error("upper level low index bits wrong");

  // type combination, one check per row of the table
  a_uc_uc: assert property (@(posedge clk_i) disable iff (rst_i)
    tbl_type == pml_pkg::MT_UC && rng == pml_pkg::MT_UC |=> rsp_o.eff_type == pml_pkg::MT_UC)
    else $error("uncacheable with uncacheable range wrong");
  a_uc_cd: assert property (@(posedge clk_i) disable iff (rst_i)
    tbl_type == pml_pkg::MT_UC && rng != pml_pkg::MT_UC |=> rsp_o.eff_type == pml_pkg::MT_CD)
    else $error("uncacheable not cache disabled");
  a_ucm_uc: assert property (@(posedge clk_i) disable iff (rst_i)
    tbl_type == pml_pkg::MT_UCM && rng == pml_pkg::MT_UC |=> rsp_o.eff_type == pml_pkg::MT_UC)
    else $error("uncacheable minus with uncacheable range wrong");
  a_ucm_cd: assert property (@(posedge clk_i) disable iff (rst_i)
    tbl_type == pml_pkg::MT_UCM && rng != pml_pkg::MT_UC && rng != pml_pkg::MT_WC
    |=> rsp_o.eff_type == pml_pkg::MT_CD)
    else $error("uncacheable minus not cache disabled");
  a_wp_uc: assert property (@(posedge clk_i) disable iff (rst_i)
    tbl_type == pml_pkg::MT_WP && rng == pml_pkg::MT_UC |=> rsp_o.eff_type == pml_pkg::MT_UC)
    else $error("write protect with uncacheable range wrong");
  a_wp_keep: assert property (@(posedge clk_i) disable iff (rst_i)
    tbl_type == pml_pkg::MT_WP && (rng == pml_pkg::MT_WP || rng == pml_pkg::MT_WB)
    |=> rsp_o.eff_type == pml_pkg::MT_WP)
    else $error("write protect not kept");
  a_wp_cd: assert property (@(posedge clk_i) disable iff (rst_i)
    tbl_type == pml_pkg::MT_WP && (rng == pml_pkg::MT_WC || rng == pml_pkg::MT_WT)
    |=> rsp_o.eff_type == pml_pkg::MT_CD)
    else $error("write protect not cache disabled");
  a_wt_uc: assert property (@(posedge clk_i) disable iff (rst_i)
    tbl_type == pml_pkg::MT_WT && rng == pml_pkg::MT_UC |=> rsp_o.eff_type == pml_pkg::MT_UC)
    else $error("write through with uncacheable range wrong");
  a_wt_keep: assert property (@(posedge clk_i) disable iff (rst_i)
    tbl_type == pml_pkg::MT_WT && (rng == pml_pkg::MT_WT || rng == pml_pkg::MT_WB)
    |=> rsp_o.eff_type == pml_pkg::MT_WT)
    else $error("write through not kept");
  a_wt_cd: assert property (@(posedge clk_i) disable iff (rst_i)
    tbl_type == pml_pkg::MT_WT && (rng == pml_pkg::MT_WC || rng == pml_pkg::MT_WP)
    |=> rsp_o.eff_type == pml_pkg::MT_CD)
    else $error("write through not cache disabled");
  a_wb_pass: assert property (@(posedge clk_i) disable iff (rst_i)
    tbl_type == pml_pkg::MT_WB && req_i.range_en |=> rsp_o.eff_type == $past(req_i.range_type))
    else $error("write back did not pass range type");

  // cache policy per effective type
  a_wp_policy: assert property (@(posedge clk_i) disable iff (rst_i)
    rsp_o.eff_type == pml_pkg::MT_WP |-> wr_hit_update_mem_o && wr_hit_invalidate_o && !wr_miss_alloc_o)
    else $error("write protect policy wrong");
  a_wt_update: assert property (@(posedge clk_i) disable iff (rst_i)
    rsp_o.eff_type == pml_pkg::MT_WT |-> wr_hit_update_mem_o && rd_miss_alloc_o && !wr_hit_invalidate_o)
    else $error("write through update policy wrong");
  c_bad_write: cover property (@(posedge clk_i) disable iff (rst_i) wr_en_i && wr_bad);
  c_good_write: cover property (@(posedge clk_i) disable iff (rst_i) wr_en_i && !wr_bad);
  c_large_hi: cover property (@(posedge clk_i) disable iff (rst_i)
    req_i.level == pml_pkg::pml_lvl_large && req_i.entry[12]);
  c_ucm_wc: cover property (@(posedge clk_i) disable iff (rst_i)
    tbl_type == pml_pkg::MT_UCM && rng == pml_pkg::MT_WC);
  c_upper_fetch: cover property (@(posedge clk_i) disable iff (rst_i)
    req_i.level == pml_pkg::pml_lvl_upper && req_i.entry[12]);
endmodule : pml_lookup

/* bench/pml_walker_model.sv */
// far-side model: walker that issues one translation lookup at a time
module pml_walker_model (
  // clock
  input wire logic clk_i,
  // lookup request toward the block
  output pml_pkg::pml_req_t req_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    req_o = '0;
  end
  // a single walker sees one table and one range setting, nothing to keep in step
  // each page is looked up under one type at a time, never through mixed aliases
  // one-cycle request; the entry is scrambled once dropped so stale bits never match
  task automatic issue(input pml_pkg::pml_level_t lvl, input logic [63:0] ent,
                       input logic [7:0] rng, input logic en);
    @(negedge clk_i);
    req_o.valid = 1'b1;
    req_o.level = lvl;
    req_o.entry = ent;
    req_o.range_type = rng;
    req_o.range_en = en;
    @(negedge clk_i);
    req_o.valid = 1'b0;
    req_o.entry = ~ent;
  endtask : issue
endmodule : pml_walker_model

/* bench/pml_lookup_tb_top.sv */
// testbench: table writes, write faults, slot selection and type combination
module pml_lookup_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i, rst_i, wr_en_i, gp, rd_al, sh_only, wr_al, upd_mem, hit_inv;
  logic [63:0] wr_data_i, tbl;
  logic [31:0] feat;
  pml_pkg::pml_req_t req;
  pml_pkg::pml_rsp_t rsp;
  int errors, n_checks;
  logic [7:0] codes [6] = '{8'h00, 8'h01, 8'h04, 8'h05, 8'h06, 8'h07};
  logic [63:0] bad [3] = '{64'h0f06050401000706, 64'h0706050402000706, 64'h0706050403000706};
  pml_lookup u_pml_lookup (.clk_i(clk_i), .rst_i(rst_i), .wr_en_i(wr_en_i),
    .wr_data_i(wr_data_i), .memtype_lookup_table_o(tbl), .general_protection_fault_o(gp),
    .feat_edx_o(feat), .req_i(req), .rsp_o(rsp), .rd_miss_alloc_o(rd_al),
    .rd_alloc_shared_only_o(sh_only), .wr_miss_alloc_o(wr_al),
    .wr_hit_update_mem_o(upd_mem), .wr_hit_invalidate_o(hit_inv));
  pml_walker_model u_pml_walker_model (.clk_i(clk_i), .req_o(req));
  task automatic cmp(input string what, input logic [63:0] exp, input logic [63:0] got);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : cmp
  function automatic logic [7:0] eff(input logic [7:0] p, input logic [7:0] m);
    case (p)
      8'h00: return (m == 8'h00) ? 8'h00 : 8'h08;
      8'h07: return (m == 8'h00 || m == 8'h01) ? m : 8'h08;
      8'h01: return 8'h01;
      8'h05: return (m == 8'h00) ? 8'h00 : (m == 8'h05 || m == 8'h06) ? 8'h05 : 8'h08;
      8'h04: return (m == 8'h00) ? 8'h00 : (m == 8'h04 || m == 8'h06) ? 8'h04 : 8'h08;
      8'h06: return m;
      default: return 8'h08;
    endcase
  endfunction : eff
  task automatic tbl_write(input logic [63:0] d, input logic fault, input logic [63:0] t);
    @(negedge clk_i);
    wr_en_i = 1'b1;
    wr_data_i = d;
    @(negedge clk_i);
    wr_en_i = 1'b0;
    cmp("fault", fault, gp);
    cmp("table", t, tbl);
  endtask : tbl_write
  task automatic look(input pml_pkg::pml_level_t l, input logic [63:0] e, input logic [7:0] m,
                      input logic en, input logic [2:0] s, input logic [7:0] t);
    logic [7:0] x;
    x = eff(t, en ? m : 8'h00);
    u_pml_walker_model.issue(l, e, m, en);
    cmp("valid", 64'h1, rsp.valid);
    cmp("slot", s, rsp.slot);
    cmp("table type", t, rsp.table_type);
    cmp("effective type", x, rsp.eff_type);
    cmp("policy", {x == 8'h04 || x == 8'h05 || x == 8'h06, x == 8'h04 || x == 8'h05,
      x == 8'h06, x != 8'h06, x == 8'h05}, {rd_al, sh_only, wr_al, upd_mem, hit_inv});
  endtask : look
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : print_verdict
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  // hang guard: far above the roughly 140 cycles the sequence needs
  initial begin
    repeat (5000) @(posedge clk_i);
    errors++;
    print_verdict();
  end
  initial begin
    errors = 0;
    n_checks = 0;
    rst_i = 1'b1;
    wr_en_i = 1'b0;
    wr_data_i = '0;
    repeat (5) @(posedge clk_i);
    @(negedge clk_i);
    rst_i = 1'b0;
    cmp("reset table", pml_pkg::TBL_RESET, tbl);
    cmp("feature", 32'h00010000, feat);
    for (int i = 0; i < 8; i++) begin
      look(pml_pkg::pml_lvl_leaf, {56'h0, i[2], 2'b0, i[1], i[0], 3'h0}, 8'h06, 1'b1, i[2:0],
        pml_pkg::TBL_RESET[8*i+:8]);
      look(pml_pkg::pml_lvl_large, {51'h0, i[2], 7'h04, i[1], i[0], 3'h0}, 8'h06, 1'b1, i[2:0],
        pml_pkg::TBL_RESET[8*i+:8]);
      look(pml_pkg::pml_lvl_upper, {51'h0, 1'b1, 7'h04, i[1], i[0], 3'h0}, 8'h06, 1'b1,
        {1'b0, i[1:0]}, pml_pkg::TBL_RESET[8*(i%4)+:8]);
    end
    $display("test slot selection done");
    tbl_write(64'h0706050401000706, 1'b0, 64'h0706050401000706);
    for (int i = 0; i < 3; i++) begin
      tbl_write(bad[i], 1'b1, 64'h0706050401000706);
    end
    $display("test table writes done");
    // no translations or lines are held here, so retyping needs no unmap or flush
    tbl_write(64'h0000070605040100, 1'b0, 64'h0000070605040100);
    for (int p = 0; p < 6; p++) begin
      for (int m = 0; m < 5; m++) begin
        look(pml_pkg::pml_lvl_leaf, {59'h0, p[1:0], 3'h0} | {56'h0, p[2], 7'h0}, codes[m], 1'b1,
          p[2:0], codes[p]);
      end
      look(pml_pkg::pml_lvl_leaf, {56'h0, p[2], 2'b0, p[1:0], 3'h0}, 8'h06, 1'b0, p[2:0],
        codes[p]);
    end
    $display("test type combination done");
    print_verdict();
  end
endmodule : pml_lookup_tb_top
